/* logic/ihs_pkg.sv */
`default_nettype none
package ihs_pkg;
    // byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    // master code: upper five bits of the byte after a start
    localparam logic [4:0] MC_PREFIX = 5'h01;
    // fixed upper address nibble when the mode pin is low
    localparam logic [3:0] ADDR_FIXED_HI = 4'h5;
    localparam int ADR_PINS = 6;
    // strap sampling: cycles after reset release before the address is frozen
    localparam logic [1:0] STRAP_DELAY = 2'h2;
    // spike filter lengths in clock cycles, fast/standard and high speed
    localparam logic [1:0] FILT_FS_LEN = 2'h3;
    localparam logic [1:0] FILT_HS_LEN = 2'h1;
    localparam int FILT_CNT_W = 2;
    // slave states, gray along address -> ack -> write data
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ACK = 3'h3,
        ST_RX = 3'h2,
        ST_TX = 3'h6,
        ST_TXACK = 3'h7,
        ST_SKIP = 3'h5
    } ihs_state_e;
endpackage
`default_nettype wire

/* logic/ihs_filt_if.sv */
`timescale 1ns/100ps
`default_nettype none
// one bus line after synchronising and spike filtering
interface ihs_filt_if;
    logic hs_sel;
    logic level;
    modport ctl (output hs_sel, input level);
    modport flt (input hs_sel, output level);
endinterface
`default_nettype wire

/* logic/ihs_line_filter.sv */
`timescale 1ns/100ps
`default_nettype none
module ihs_line_filter
    import ihs_pkg::*;
#(
    parameter logic [FILT_CNT_W-1:0] FS_LEN = FILT_FS_LEN,
    parameter logic [FILT_CNT_W-1:0] HS_LEN = FILT_HS_LEN
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic pin,
    ihs_filt_if.flt f
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic [FILT_CNT_W-1:0] cnt;
    } ihs_filt_s;

    ihs_filt_s r;
    ihs_filt_s n;
    logic [FILT_CNT_W-1:0] len;

    // shorter filter in high speed: less suppression, less delay
    assign len = f.hs_sel ? HS_LEN : FS_LEN;
    assign f.level = r.lvl;

    // two-flop sync, then accept a new level only after len equal samples
    always_comb
    begin
        n = r;
        n.s1 = pin;
        n.s2 = r.s1;
        if (r.s2 != r.lvl)
        begin
            if (r.cnt + 1'b1 >= len)
            begin
                n.lvl = r.s2;
                n.cnt = '0;
            end
            else
            begin
                n.cnt = r.cnt + 1'b1;
            end
        end
        else
        begin
            n.cnt = '0;
        end
    end

    // idle bus is high
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            r <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, cnt: '0};
        else
            r <= n;
    end
endmodule
`default_nettype wire

/* logic/ihs_i2c_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module ihs_i2c_slave
    import ihs_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic address_mode_select_pin,
    input wire logic [ADR_PINS-1:0] adr_pins,
    input wire logic force_high_speed_bit,
    output logic hs_mode,
    output logic filter_hs_sel,
    output logic slope_hs_sel,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    output logic reg_re,
    input wire logic [7:0] reg_rdata
);
    typedef struct packed {
        ihs_state_e st;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic we;
        logic re;
        logic hs;
        logic mc;
        logic oe;
        logic scl_p;
        logic sda_p;
        logic mode_s1;
        logic mode_s2;
        logic [ADR_PINS-1:0] adr_s1;
        logic [ADR_PINS-1:0] adr_s2;
        logic [1:0] lat_cnt;
        logic latched;
        logic [6:0] dev;
    } ihs_core_s;
    // edge detectors start at the idle-high bus level, so no false edge after reset
    localparam ihs_core_s CORE_RST = '{st: ST_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};
    ihs_core_s r;
    ihs_core_s n;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic hs_eff;
    ihs_filt_if scl_f ();
    ihs_filt_if sda_f ();
    ihs_line_filter u_scl_filt (
        .clock(clock),
        .rstn(rstn),
        .pin(scl_i),
        .f(scl_f)
    );
    ihs_line_filter u_sda_filt (
        .clock(clock),
        .rstn(rstn),
        .pin(sda_i),
        .f(sda_f)
    );
    // forced mode overrides the master-code state
    assign hs_eff = r.hs | force_high_speed_bit;
    assign scl_f.hs_sel = hs_eff;
    assign sda_f.hs_sel = hs_eff;
    assign scl = scl_f.level;
    assign sda = sda_f.level;
    // bus events from filtered levels
    assign scl_rise = scl & ~r.scl_p;
    assign scl_fall = ~scl & r.scl_p;
    assign start_ev = scl & r.scl_p & ~sda & r.sda_p;
    assign stop_ev = scl & r.scl_p & sda & ~r.sda_p;
    // open-drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe = r.oe;
    assign hs_mode = hs_eff;
    assign filter_hs_sel = hs_eff;
    assign slope_hs_sel = hs_eff;
    assign reg_addr = r.ptr;
    assign reg_wdata = r.wdata;
    assign reg_we = r.we;
    assign reg_re = r.re;

    // next state
    always_comb
    begin
        n = r;
        n.we = 1'b0;
        n.re = 1'b0;
        n.scl_p = scl;
        n.sda_p = sda;
        n.mode_s1 = address_mode_select_pin;
        n.mode_s2 = r.mode_s1;
        n.adr_s1 = adr_pins;
        n.adr_s2 = r.adr_s1;
        // straps frozen once, later pin changes ignored
        if (!r.latched)
        begin
            if (r.lat_cnt == STRAP_DELAY)
            begin
                n.latched = 1'b1;
                n.dev = r.mode_s2 ? {1'b0, r.adr_s2} : {ADDR_FIXED_HI, r.adr_s2[2:0]};
            end
            else
            begin
                n.lat_cnt = r.lat_cnt + 2'h1;
            end
        end
        if (stop_ev)
        begin
            n.st = ST_IDLE;
            n.oe = 1'b0;
            n.mc = 1'b0;
            n.hs = 1'b0;
        end
        else if (start_ev)
        begin
            // repeated start keeps hs untouched
            n.st = ST_ADDR;
            n.bitc = '0;
            n.oe = 1'b0;
            n.mc = 1'b0;
        end
        else
        begin
            case (r.st)
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise && r.bitc != BYTE_BITS)
                    begin
                        n.sh = {r.sh[6:0], sda};
                        n.bitc = r.bitc + 4'h1;
                    end
                    else if (scl_fall && r.bitc == BYTE_BITS)
                    begin
                        n.bitc = '0;
                        if (r.st == ST_RX)
                        begin
                            n.oe = 1'b1;
                            n.st = ST_ACK;
                            n.first = 1'b0;
                            if (r.first)
                                n.ptr = r.sh;
                            else
                            begin
                                n.we = 1'b1;
                                n.wdata = r.sh;
                            end
                        end
                        else if (r.latched && r.sh[7:1] == r.dev)
                        begin
                            n.oe = 1'b1;
                            n.st = ST_ACK;
                            n.rw = r.sh[0];
                            n.first = ~r.sh[0];
                        end
                        else if (r.sh[7:3] == MC_PREFIX && !hs_eff)
                        begin
                            // master code is never acknowledged by a slave
                            n.mc = 1'b1;
                            n.st = ST_SKIP;
                        end
                        else
                        begin
                            n.st = ST_SKIP;
                        end
                    end
                end
                ST_ACK, ST_TXACK:
                begin
                    if (r.st == ST_TXACK && scl_rise && sda)
                    begin
                        n.st = ST_SKIP;
                    end
                    else if (scl_fall)
                    begin
                        n.bitc = '0;
                        if (r.rw)
                        begin
                            // same pointer every byte: fifo drain or polling
                            n.sh = reg_rdata;
                            n.re = 1'b1;
                            n.oe = ~reg_rdata[7];
                            n.st = ST_TX;
                        end
                        else
                        begin
                            n.oe = 1'b0;
                            n.st = ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (r.bitc == LAST_TX_BIT)
                        begin
                            n.oe = 1'b0;
                            n.st = ST_TXACK;
                        end
                        else
                        begin
                            n.bitc = r.bitc + 4'h1;
                            n.sh = {r.sh[6:0], 1'b0};
                            n.oe = ~r.sh[6];
                        end
                    end
                end
                ST_SKIP:
                begin
                    n.oe = 1'b0;
                    // hs only after the master code got its not-acknowledge
                    if (r.mc && scl_rise)
                    begin
                        n.mc = 1'b0;
                        n.hs = sda;
                    end
                end
                default:
                begin
                    n.oe = 1'b0;
                end
            endcase
        end
    end

    // reset lands in fast/standard, idle
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            r <= CORE_RST;
        else
            r <= n;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_hs_needs_nack: assert property ($rose(r.hs) |-> $past(r.mc) && $past(sda) && $past(scl_rise))
        else $error("hs entered without master code nack");
    a_addr_ack: assert property (r.st == ST_ADDR && scl_fall && r.bitc == BYTE_BITS && r.latched
        && r.sh[7:1] == r.dev && !stop_ev && !start_ev |=> sda_oe && r.st == ST_ACK)
        else $error("own address not acknowledged");
    a_stop_exits_hs: assert property (stop_ev |=> !r.hs && r.st == ST_IDLE)
        else $error("stop did not leave hs");
    a_rstart_keeps_hs: assert property (start_ev && r.hs |=> r.hs && r.st == ST_ADDR)
        else $error("repeated start dropped hs");
    a_hs_settings: assert property (hs_mode == (r.hs || force_high_speed_bit)
        && filter_hs_sel == hs_mode && slope_hs_sel == hs_mode)
        else $error("filter or slope setting disagrees with mode");
    a_force_hs: assert property (force_high_speed_bit |-> hs_mode && scl_f.hs_sel)
        else $error("force bit without hs");
    a_no_mc_fs: assert property (!r.mc && !r.hs |=> !r.hs)
        else $error("hs without master code");
    a_ptr_stable: assert property (r.st == ST_TX || r.st == ST_TXACK |=> $stable(reg_addr))
        else $error("read pointer moved in read frame");
    a_nack_release: assert property (r.st == ST_TXACK && scl_rise && sda && !stop_ev
        |=> !sda_oe [*2])
        else $error("data line held after master nack");
    a_strap_frozen: assert property (r.latched |=> r.latched && $stable(r.dev))
        else $error("slave address changed after latch");
    a_write_ptr_first: assert property (reg_we |-> $past(r.st) == ST_RX && !$past(r.first))
        else $error("data written before register address");

    c_hs_entry: cover property ($rose(r.hs));
    c_read_byte: cover property (reg_re ##[1:300] reg_re);
    c_write_byte: cover property (reg_we);
    c_hs_rstart: cover property (r.hs && start_ev);
endmodule
`default_nettype wire

/* test/ihs_bus_master.sv */
`timescale 1ns/100ps
`default_nettype none
// bus master model: open drain, a released line reads high through the pull-up
module ihs_bus_master
#(
    parameter time QTR = 320
)
(
    output var logic scl,
    output var logic sda_drv,
    input wire logic sda_in
);
    // idle bus: both lines released
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // start or repeated start; sda only falls while scl is high
    task automatic start();
        sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    // stop: sda rises while scl is high
    task automatic stop();
        sda_drv = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b1;
        #QTR;
    endtask

    // one bit; data changes a quarter after the fall, so the slave answer lands first
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        #QTR scl = 1'b1;
        #QTR s = sda_in;
        scl = 1'b0;
        #QTR;
    endtask

    // msb first, then the ninth bit; ack_out high releases it, the last read gets no ack
    task automatic byte_io(input logic [7:0] tx, input logic ack_out,
        output logic [7:0] rx, output logic ack_in);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_out, ack_in);
    endtask
endmodule
`default_nettype wire

/* test/test_i2c_slave_hs_register_access.sv */
`timescale 1ns/100ps
`default_nettype none
module test_i2c_slave_hs_register_access;
    import ihs_pkg::*;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic mode_pin = 1'b0;
    logic [ADR_PINS-1:0] adr = 6'h03;
    logic force_hs = 1'b0;
    logic scl;
    logic m_sda;
    logic sda_line;
    logic sda_o;
    logic sda_oe;
    logic hs_mode;
    logic filt_hs;
    logic slope_hs;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_we;
    logic reg_re;
    logic [7:0] reg_rdata;
    logic [15:0] wq[$];
    logic [7:0] rq[$];
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    // wired-and bus; lone master and slave keep the lines clean
    assign sda_line = m_sda & (sda_oe ? sda_o : 1'b1);
    // register file stand-in: contents derived from the address
    assign reg_rdata = reg_addr ^ 8'h5a;

    always #20 clock = ~clock;

    ihs_i2c_slave i_ihs_i2c_slave (.clock(clock), .rstn(rstn), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .address_mode_select_pin(mode_pin), .adr_pins(adr),
        .force_high_speed_bit(force_hs), .hs_mode(hs_mode), .filter_hs_sel(filt_hs),
        .slope_hs_sel(slope_hs), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));

    ihs_bus_master i_master (.scl(scl), .sda_drv(m_sda), .sda_in(sda_line));

    // record register writes as address and data pairs, reads as addresses
    always @(posedge clock)
    begin
        if (reg_we === 1'b1)
        begin
            wq.push_back({reg_addr, reg_wdata});
        end
        if (reg_re === 1'b1)
        begin
            rq.push_back(reg_addr);
        end
    end

    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_fail++;
            finish_test();
        end
    end

    task automatic chk(input bit ok, input string msg);
        compares++;
        if (!ok)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic send(input logic [7:0] tx, input logic exp_ack, input string msg);
        logic [7:0] rx;
        logic ack;
        i_master.byte_io(tx, 1'b1, rx, ack);
        chk(ack === exp_ack, msg);
    endtask

    task automatic recv(input logic [7:0] exp, input logic ack_out);
        logic [7:0] rx;
        logic ack;
        i_master.byte_io(8'hff, ack_out, rx, ack);
        chk(rx === exp, "read data");
    endtask

    task automatic t_reset();
        chk(hs_mode === 1'b0 && filt_hs === 1'b0 && slope_hs === 1'b0, "reset speed");
        chk(sda_oe === 1'b0 && sda_o === 1'b0, "reset sda released");
    endtask

    // straps moved after the latch must not move the address
    task automatic t_write();
        @(negedge clock);
        adr = 6'h00;
        wq.delete();
        i_master.start();
        send(8'h56, 1'b0, "write address");
        send(8'h12, 1'b0, "register byte");
        send(8'ha5, 1'b0, "data one");
        send(8'h3c, 1'b0, "data two");
        i_master.stop();
        chk(wq.size() == 2, "write count");
        chk(wq[0] === 16'h12a5 && wq[1] === 16'h123c, "same register");
    endtask

    // pointer set by a bare write, read back over a repeated start, then again later
    task automatic t_read();
        rq.delete();
        i_master.start();
        send(8'h56, 1'b0, "set address");
        send(8'h40, 1'b0, "pointer byte");
        i_master.start();
        send(8'h57, 1'b0, "read address");
        recv(8'h1a, 1'b0);
        recv(8'h1a, 1'b0);
        recv(8'h1a, 1'b1);
        chk(sda_oe === 1'b0, "release after nack");
        i_master.stop();
        i_master.start();
        send(8'h57, 1'b0, "second read address");
        recv(8'h1a, 1'b1);
        i_master.stop();
        // one fetch per byte sent, all from the same pointer; the nack fetches nothing
        chk(rq.size() == 4 && rq[0] === 8'h40 && rq[3] === 8'h40, "read fetches");
        chk(rq[1] === 8'h40 && rq[2] === 8'h40, "read fetch address");
        chk(hs_mode === 1'b0, "no master code");
    endtask

    task automatic t_wrong();
        i_master.start();
        send(8'h58, 1'b1, "foreign address");
        i_master.stop();
    endtask

    task automatic t_hs();
        i_master.start();
        send(8'h09, 1'b1, "master code");
        chk(hs_mode === 1'b1 && filt_hs === 1'b1 && slope_hs === 1'b1, "hs setting");
        i_master.start();
        send(8'h56, 1'b0, "hs address");
        send(8'h21, 1'b0, "hs pointer");
        i_master.start();
        chk(hs_mode === 1'b1, "hs over restart");
        send(8'h57, 1'b0, "hs read address");
        recv(8'h7b, 1'b1);
        i_master.stop();
        chk(hs_mode === 1'b0, "stop ends hs");
    endtask

    task automatic t_force();
        @(negedge clock);
        force_hs = 1'b1;
        wq.delete();
        @(negedge clock);
        chk(hs_mode === 1'b1 && filt_hs === 1'b1, "forced hs");
        i_master.start();
        send(8'h56, 1'b0, "forced address");
        send(8'h33, 1'b0, "forced pointer");
        send(8'h44, 1'b0, "forced data");
        i_master.start();
        send(8'h57, 1'b0, "forced read address");
        recv(8'h69, 1'b1);
        i_master.stop();
        chk(hs_mode === 1'b1 && wq[0] === 16'h3344, "forced after stop");
        @(negedge clock);
        force_hs = 1'b0;
        @(negedge clock);
        chk(hs_mode === 1'b0, "force dropped");
    endtask

    // reset in mid-frame while in hs, then straps with the mode pin high
    task automatic t_strap();
        i_master.start();
        send(8'h09, 1'b1, "code before reset");
        chk(hs_mode === 1'b1, "hs before reset");
        mode_pin = 1'b1;
        adr = 6'h1b;
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        repeat (8) @(negedge clock);
        t_reset();
        i_master.stop();
        i_master.start();
        send(8'h56, 1'b1, "old address after reset");
        i_master.stop();
        i_master.start();
        send(8'h36, 1'b0, "pin address");
        send(8'h07, 1'b0, "pin pointer");
        i_master.start();
        send(8'h37, 1'b0, "pin read address");
        recv(8'h5d, 1'b1);
        i_master.stop();
    endtask

    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // bus traffic waits for the strap latch after reset release
    initial
    begin
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        repeat (8) @(negedge clock);
        t_reset();
        t_write();
        t_read();
        t_wrong();
        t_hs();
        t_force();
        t_strap();
        finish_test();
    end
endmodule
`default_nettype wire
